// file: bench/sfr_pins.sv
// port pin model: open-drain lines with pull-ups
`timescale 1ns/1ns
module sfr_pins (
	input  wire logic [7:0] upper_port_out,
	input  wire logic [7:0] upper_port_oe_n,
	input  wire logic [7:0] alt_port_out,
	input  wire logic [7:0] alt_port_oe_n,
	input  wire logic [7:0] ext_pull_n,
	output logic      [7:0] upper_port_in,
	output logic      [7:0] alt_port_in
);
	// released lines float high unless the outside pulls them low
	assign upper_port_in = (upper_port_out & ~upper_port_oe_n) | (ext_pull_n & upper_port_oe_n);
	assign alt_port_in   = (alt_port_out & ~alt_port_oe_n) | (ext_pull_n & alt_port_oe_n);
endmodule : sfr_pins

// file: bench/sfr_slice_props.sv
// checker of the sfr slice port behaviour
`timescale 1ns/1ns
module sfr_slice_props (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [7:0]  avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_load,
	input wire logic        ext_access,
	input wire logic [15:0] ext_addr,
	input wire logic        strobe2_match,
	input wire logic [7:0]  upper_port_out,
	input wire logic [7:0]  upper_port_oe_n,
	input wire logic [5:0]  irq_req,
	input wire logic [5:0]  irq_take
);
	// shadows of written registers, updated on the edge a write is taken
	logic [7:0] ie;
	logic [7:0] bl;
	logic [7:0] bh;
	wire        hit = avs_write && !avs_waitrequest;
	always_ff @(posedge clk) begin
		ie <= rst ? 8'h00 : (hit && avs_address == 8'hA8) ? avs_writedata : ie;
		bl <= rst ? 8'h00 : (hit && avs_address == 8'hAC) ? avs_writedata : bl;
		bh <= rst ? 8'h00 : (hit && avs_address == 8'hAD) ? avs_writedata : bh;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_irq_gate: assert property (!ie[7] |-> irq_take == 6'h00)
		else $error("take with gate off");
	chk_irq_timers: assert property ((irq_take & 6'h2A) == (irq_req & ie[5:0] & {6{ie[7]}} & 6'h2A))
		else $error("timer take wrong");
	chk_irq_serial: assert property (irq_take[4] == (irq_req[4] & ie[4] & ie[7]))
		else $error("serial take wrong");
	chk_irq_ext: assert property ((irq_take & 6'h05) == (irq_req & ie[5:0] & {6{ie[7]}} & 6'h05))
		else $error("ext take wrong");
	chk_tx_word: assert property (hit && avs_address == 8'h99 |=> tx_load && tx_data == $past(avs_writedata))
		else $error("tx load wrong");
	chk_tx_pulse: assert property (tx_load |=> !tx_load)
		else $error("tx load held");
	chk_base_match: assert property (strobe2_match == $past(ext_access && ext_addr == {bh, bl}))
		else $error("match wrong");
	chk_upper_drive: assert property (ext_access |-> upper_port_oe_n == 8'h00 && upper_port_out == ext_addr[15:8])
		else $error("upper address wrong");
	cover property (tx_load);
	cover property (strobe2_match);
	cover property (irq_take != 6'h00);
endmodule : sfr_slice_props
bind sfr_slice sfr_slice_props sfr_slice_props_inst (.*);

// file: bench/sfr_slice_test.sv
// self-checking bench for the sfr slice
`timescale 1ns/1ns
module sfr_slice_test;
	logic clk = 0, rst = 1, rmw_read = 0, rx_load = 0, ext_access = 0, ext_read = 0, ext_write = 0;
	logic avs_read = 0, avs_write = 0, avs_waitrequest, tx_load, strobe2_match, timer1_count_in, timer0_count_in;
	logic [7:0] avs_address = 0, avs_writedata = 0, rx_data = 0, ext_pull_n = 8'hFF, q, avs_readdata, tx_data;
	logic [7:0] upper_port_in, upper_port_out, upper_port_oe_n, alt_port_in, alt_port_out, alt_port_oe_n;
	logic [15:0] ext_addr = 0;
	logic [3:0]  strobe_sel = 0, strobe_out;
	logic [5:0]  irq_req = 0, irq_take;
	int          err_count = 0, checked = 0;
	sfr_slice sfr_slice_inst (.*);
	sfr_pins sfr_pins_inst (.*);
	always #5 clk = ~clk;
	task chk(input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	// waitrequest and read data are judged with the values they hold as the edge arrives
	task acc(input logic w, input logic [7:0] a, d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk iff avs_waitrequest === 1'b0);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk);
	endtask : acc
	task end_of_test;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	initial begin
		#20000;
		err_count++;
		end_of_test;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		irq_req <= 6'h3F;
		rx_data <= 8'h5A;
		rx_load <= 1;
		acc(1, 8'hA8, 8'hFF);
		rx_load <= 0;
		acc(0, 8'hA8, 0); chk(q, 8'hBF);
		chk({2'b00, irq_take}, 8'h3F);
		acc(1, 8'hA8, 8'h14); chk({2'b00, irq_take}, 8'h00);
		acc(1, 8'hA8, 8'h95); chk({2'b00, irq_take}, 8'h15);
		acc(1, 8'h99, 8'hA5); chk(tx_data, 8'hA5);
		acc(0, 8'h99, 0); chk(q, 8'h5A);
		acc(1, 8'hAC, 8'h34);
		acc(1, 8'hAD, 8'h12);
		acc(0, 8'hAD, 0); chk(q, 8'h12);
		acc(0, 8'hAC, 0); chk(q, 8'h34);
		ext_addr <= 16'h1234;
		ext_access <= 1;
		ext_read <= 1;
		strobe_sel <= 4'hF;
		repeat (3) @(posedge clk);
		chk({7'd0, strobe2_match}, 8'h01);
		chk({4'h0, strobe_out}, 8'h00);
		acc(0, 8'hA0, 0); chk(q, 8'h12);
		rmw_read <= 1;
		acc(0, 8'hA0, 0); chk(q, 8'hFF);
		rmw_read <= 0;
		acc(0, 8'hB0, 0); chk(q, 8'h7F);
		acc(1, 8'hAE, 8'hF0);
		repeat (2) @(posedge clk);
		chk({4'h0, strobe_out}, 8'h0F);
		acc(0, 8'hAE, 0); chk(q, 8'hF0);
		ext_addr <= 16'h1235;
		ext_pull_n <= 8'hEF;
		repeat (3) @(posedge clk);
		chk({7'd0, strobe2_match}, 8'h00);
		acc(0, 8'hB0, 0); chk(q, 8'h6F);
		chk({6'h00, timer1_count_in, timer0_count_in}, 8'h02);
		acc(0, 8'hB1, 0); chk(q, 8'h01);
		acc(1, 8'h55, 8'h77);
		acc(0, 8'h55, 0); chk(q, 8'h00);
		end_of_test;
	end
endmodule : sfr_slice_test

// file: verilog/sfr_pkg.sv
// package of constants and register map for the sfr slice
// What this block does
// (RULE1) serial buffer reads return receive holding, writes load transmit holding
// (RULE2) receive and transmit holding are two separate bytes at one address
// (RULE3) upper-address port drives high address bits during external accesses
// (RULE4) upper-address pins are bidirectional with pull-up when not addressing
// (RULE5) interrupt enable bit 7 gates every interrupt request
// (RULE6) enable bits 5, 3, 1 permit timer 2, timer 1, timer 0
// (RULE7) enable bit 4 permits the serial port interrupt
// (RULE8) enable bits 2 and 0 permit external interrupts 1 and 0
// (RULE9) low base register holds low address byte of strobe 2 comparator
// (RULE10) high base register holds high address byte of strobe 2 comparator
// (RULE11) polarity bit 7 set makes strobe pin 3 active high
// (RULE12) polarity bit 7 clear makes strobe pin 3 active low
// (RULE13) polarity bits 6, 5, 4 do the same for strobe pins 2, 1, 0
// (RULE14) ordinary reads of the general port return pin levels
// (RULE15) read-modify-write reads of the general port return the output latch
// (RULE16) general port bits 7, 6 are read/write strobes, 5, 4 timer inputs
// (RULE17) strobe 2 asserts only while external address equals its base registers
// (RULE18) interrupt enable bit 6 ignores writes and reads zero
package sfr_pkg;
	localparam logic [7:0] ADDR_SERIAL_DATA_BUFFER  = 8'h99;
	localparam logic [7:0] ADDR_UPPER_ADDRESS_PORT  = 8'hA0;
	localparam logic [7:0] ADDR_IRQ_MASK_REG        = 8'hA8;
	localparam logic [7:0] ADDR_STROBE2_BASE_LOW    = 8'hAC;
	localparam logic [7:0] ADDR_STROBE2_BASE_HIGH   = 8'hAD;
	localparam logic [7:0] ADDR_STROBE_POLARITY     = 8'hAE;
	localparam logic [7:0] ADDR_ALT_FUNCTION_PORT   = 8'hB0;
	localparam logic [7:0] ADDR_STATUS              = 8'hB1;
	localparam logic [7:0] RESET_PORT               = 8'hFF;
	localparam logic [7:0] RESET_ZERO               = 8'h00;
	localparam logic [7:0] IRQ_MASK_WRITABLE        = 8'hBF;
	localparam int         GLOBAL_GATE_BIT          = 7;
	localparam int         POL_LOW_BIT              = 4;
	localparam int         STATUS_PENDING_BIT       = 0;
	localparam int         STATUS_RX_FULL_BIT       = 1;
endpackage : sfr_pkg

// file: verilog/sfr_slice.sv
// special function register slice: serial buffer, ports, irq enables, strobes
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
module sfr_slice (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] avs_address,
	input  wire logic       avs_read,
	input  wire logic       avs_write,
	input  wire logic [7:0] avs_writedata,
	output logic      [7:0] avs_readdata,
	output logic            avs_waitrequest,
	input  wire logic       rmw_read,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_load,
	output logic      [7:0] tx_data,
	output logic            tx_load,
	input  wire logic       ext_access,
	input  wire logic       ext_read,
	input  wire logic       ext_write,
	input  wire logic [15:0] ext_addr,
	input  wire logic [3:0] strobe_sel,
	output logic      [3:0] strobe_out,
	output logic            strobe2_match,
	input  wire logic [7:0] upper_port_in,
	output logic      [7:0] upper_port_out,
	output logic      [7:0] upper_port_oe_n,
	input  wire logic [7:0] alt_port_in,
	output logic      [7:0] alt_port_out,
	output logic      [7:0] alt_port_oe_n,
	output logic            timer1_count_in,
	output logic            timer0_count_in,
	input  wire logic [5:0] irq_req,
	output logic      [5:0] irq_take
);
	import sfr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] rx_hold;
		logic [7:0] tx_hold;
		logic       tx_pulse;
		logic       rx_full;
		logic [7:0] upper_latch;
		logic [7:0] irq_mask;
		logic [7:0] base_low;
		logic [7:0] base_high;
		logic [3:0] pol;
		logic [7:0] alt_latch;
		logic [7:0] rdata;
		logic       ack;
		logic [3:0] strobe;
		logic       match;
	} sfr_state_type;

	sfr_state_type state;
	sfr_state_type next_state;

	// open-drain style pull-up port: drive only a latched zero
	function automatic logic [7:0] sfr_oe_n(input logic [7:0] latch);
		sfr_oe_n = latch;
	endfunction : sfr_oe_n

	logic       req;
	logic       take;
	logic       hit;
	logic [7:0] dec;
	logic [3:0] active;
	logic       pend;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_state.tx_pulse = 1'b0;
		next_state.ack = 1'b0;
		req = (avs_read | avs_write) & ~state.ack;
		// a transfer completes only at the edge where waitrequest is seen low
		take = (avs_read | avs_write) & state.ack;
		hit = 1'b1;
		dec = RESET_ZERO;
		pend = |(irq_req & state.irq_mask[5:0]) & state.irq_mask[GLOBAL_GATE_BIT];
		if (avs_address == ADDR_SERIAL_DATA_BUFFER) begin
			dec = state.rx_hold; // see (RULE1)
		end else if (avs_address == ADDR_UPPER_ADDRESS_PORT) begin
			dec = rmw_read ? state.upper_latch : upper_port_in;
		end else if (avs_address == ADDR_IRQ_MASK_REG) begin
			dec = state.irq_mask & IRQ_MASK_WRITABLE; // see (RULE18)
		end else if (avs_address == ADDR_STROBE2_BASE_LOW) begin
			dec = state.base_low;
		end else if (avs_address == ADDR_STROBE2_BASE_HIGH) begin
			dec = state.base_high;
		end else if (avs_address == ADDR_STROBE_POLARITY) begin
			dec = {state.pol, 4'h0};
		end else if (avs_address == ADDR_ALT_FUNCTION_PORT) begin
			dec = rmw_read ? state.alt_latch : alt_port_in; // see (RULE14) (RULE15)
		end else if (avs_address == ADDR_STATUS) begin
			dec = {6'h00, state.rx_full, pend};
		end else begin
			hit = 1'b0;
		end
		if (req) begin
			next_state.ack = 1'b1;
			next_state.rdata = avs_read ? dec : RESET_ZERO;
		end
		if (take && avs_read && avs_address == ADDR_SERIAL_DATA_BUFFER) begin
			next_state.rx_full = 1'b0;
		end
		if (rx_load) begin
			next_state.rx_hold = rx_data; // see (RULE2)
			next_state.rx_full = 1'b1;
		end
		if (take && avs_write && hit) begin
			if (avs_address == ADDR_SERIAL_DATA_BUFFER) begin
				next_state.tx_hold = avs_writedata; // see (RULE1) (RULE2)
				next_state.tx_pulse = 1'b1;
			end else if (avs_address == ADDR_UPPER_ADDRESS_PORT) begin
				next_state.upper_latch = avs_writedata;
			end else if (avs_address == ADDR_IRQ_MASK_REG) begin
				next_state.irq_mask = avs_writedata & IRQ_MASK_WRITABLE; // see (RULE18)
			end else if (avs_address == ADDR_STROBE2_BASE_LOW) begin
				next_state.base_low = avs_writedata; // see (RULE9)
			end else if (avs_address == ADDR_STROBE2_BASE_HIGH) begin
				next_state.base_high = avs_writedata; // see (RULE10)
			end else if (avs_address == ADDR_STROBE_POLARITY) begin
				next_state.pol = avs_writedata[7:POL_LOW_BIT];
			end else if (avs_address == ADDR_ALT_FUNCTION_PORT) begin
				next_state.alt_latch = avs_writedata;
			end
		end
		next_state.match = ext_access && (ext_addr == {state.base_high, state.base_low}); // see (RULE17)
		active = strobe_sel & {4{ext_read | ext_write}};
		active[2] = active[2] & next_state.match; // see (RULE17)
		next_state.strobe = ~(active ^ state.pol); // see (RULE11) (RULE12) (RULE13)
		if (rst) begin
			next_state = '0;
			next_state.upper_latch = RESET_PORT;
			next_state.alt_latch = RESET_PORT;
			next_state.strobe = 4'hF;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	assign avs_waitrequest = (avs_read | avs_write) & ~state.ack;
	assign avs_readdata    = state.rdata;
	assign tx_data         = state.tx_hold;
	assign tx_load         = state.tx_pulse;
	assign strobe_out      = state.strobe;
	assign strobe2_match   = state.match;

	// external access overrides the latch with the high address byte
	always_comb begin
		if (ext_access) begin
			upper_port_out  = ext_addr[15:8]; // see (RULE3)
			upper_port_oe_n = 8'h00;
		end else begin
			upper_port_out  = 8'h00;
			upper_port_oe_n = sfr_oe_n(state.upper_latch); // see (RULE4)
		end
	end

	// bits 7 and 6 carry the read and write strobes during external accesses
	always_comb begin
		alt_port_out  = 8'h00;
		alt_port_oe_n = sfr_oe_n(state.alt_latch);
		if (ext_access) begin
			alt_port_oe_n[7] = ~ext_read; // see (RULE16)
			alt_port_oe_n[6] = ~ext_write; // see (RULE16)
		end
	end
	assign timer1_count_in = alt_port_in[5]; // see (RULE16)
	assign timer0_count_in = alt_port_in[4]; // see (RULE16)

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_irq
			assign irq_take[g] = irq_req[g] & state.irq_mask[g] & state.irq_mask[GLOBAL_GATE_BIT]; // see (RULE5) (RULE6) (RULE7) (RULE8)
		end
	endgenerate
endmodule : sfr_slice
